/* File: verilog/icp_packet_engine.v */
/*
  I2C target packet engine: bit level target, control word parser,
  checksum, write queue towards the register space, read fetch and
  transmit buffer, EEPROM reload trigger.
  Assumes scl/sda come from pins (synchronised here), the register
  space answers reads with rd_ack and drains writes via wr_ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "icp_defs.vh"
module icp_packet_engine (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire [6:0] target_addr_cfg,
  input wire target_addr_load,
  output wire [6:0] target_addr,
  output wire wr_valid,
  input wire wr_ready,
  output wire [21:0] wr_addr,
  output wire [31:0] wr_data,
  output wire wr_wide,
  output wire rd_req,
  output wire [21:0] rd_addr,
  input wire rd_ack,
  input wire [31:0] rd_data,
  input wire motor_stationary,
  output wire eeprom_reload
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one byte through the checksum, msb first
  function [7:0] crc8_step;
    input [7:0] c;
    input [7:0] b;
    reg [7:0] x;
    integer k;
    begin
      x = c ^ b;
      for (k = 0; k < 8; k = k + 1) begin
        x = x[7] ? ({x[6:0], 1'b0} ^ `ICP_CRC_POLY) : {x[6:0], 1'b0};
      end
      crc8_step = x;
    end
  endfunction

  // data bytes announced by a length code
  function [3:0] len_bytes;
    input [1:0] len;
    begin
      case (len)
        `ICP_LEN_16: len_bytes = 4'h2;
        `ICP_LEN_32: len_bytes = 4'h4;
        `ICP_LEN_64: len_bytes = 4'h8;
        default: len_bytes = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
    end
  end
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_ev = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  wire stop_ev = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // ----------------------------------------------------------------
  // target address register
  // ----------------------------------------------------------------
  reg [6:0] tgt_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tgt_q <= `ICP_TARGET_ADDR_RST;
    end else if (target_addr_load) begin
      tgt_q <= target_addr_cfg;
    end
  end
  assign target_addr = tgt_q;

  // ----------------------------------------------------------------
  // bit level target
  // ----------------------------------------------------------------
  localparam B_IDLE = 7'h01;
  localparam B_ADDR = 7'h02;
  localparam B_AACK = 7'h04;
  localparam B_RX = 7'h08;
  localparam B_RACK = 7'h10;
  localparam B_TX = 7'h20;
  localparam B_TACK = 7'h40;
  localparam P_IDLE = 4'h1;
  localparam P_RD = 4'h2;
  localparam P_CRC = 4'h4;
  localparam P_PUSH = 4'h8;

  reg [6:0] bst_q;
  reg [3:0] bcnt_q;
  reg [7:0] sh_q;
  reg oe_q;
  reg rdm_q;
  reg [3:0] pst_q;
  reg tx_valid_q;
  wire [7:0] tx_byte;
  wire is_rd = sh_q[0];
  wire byte8 = scl_fall & (bcnt_q == 4'h8);
  // write start refused while a request is still being worked off
  wire addr_ack = (sh_q[7:1] == tgt_q) & (is_rd ? tx_valid_q : (pst_q == P_IDLE));
  wire addr_ev = (bst_q == B_ADDR) & byte8 & addr_ack;
  wire rx_ev = (bst_q == B_RX) & byte8;
  wire tx_done = (bst_q == B_TX) & byte8;

  // sda is open drain: only ever pulled low
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bst_q <= B_IDLE;
      bcnt_q <= 4'h0;
      sh_q <= 8'h00;
      oe_q <= 1'b0;
      rdm_q <= 1'b0;
    end else if (start_ev) begin
      bst_q <= B_ADDR;
      bcnt_q <= 4'h0;
      oe_q <= 1'b0;
    end else if (stop_ev) begin
      bst_q <= B_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (bst_q)
        B_ADDR, B_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            bcnt_q <= bcnt_q + 4'h1;
          end else if (byte8) begin
            bcnt_q <= 4'h0;
            if (bst_q == B_RX) begin
              oe_q <= 1'b1;
              bst_q <= B_RACK;
            end else if (addr_ack) begin
              oe_q <= 1'b1;
              rdm_q <= is_rd;
              bst_q <= B_AACK;
            end else begin
              bst_q <= B_IDLE; // not us, or not ready: no ack
            end
          end
        end
        B_AACK, B_TACK: begin
          if (bst_q == B_TACK && scl_rise && sda_s2_q) begin
            bst_q <= B_IDLE; // controller ended the read
          end else if (scl_fall) begin
            if (rdm_q) begin
              oe_q <= ~tx_byte[7];
              sh_q <= {tx_byte[6:0], 1'b0};
              bcnt_q <= 4'h1;
              bst_q <= B_TX;
            end else begin
              oe_q <= 1'b0;
              bst_q <= B_RX;
            end
          end
        end
        B_RACK: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            bst_q <= B_RX;
          end
        end
        B_TX: begin
          if (byte8) begin
            oe_q <= 1'b0;
            bst_q <= B_TACK;
          end else if (scl_fall) begin
            oe_q <= ~sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            bcnt_q <= bcnt_q + 4'h1;
          end
        end
        default: bst_q <= B_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // ----------------------------------------------------------------
  // packet layer
  // ----------------------------------------------------------------
  reg pw_q;
  reg [3:0] pidx_q;
  reg [23:0] cw_q;
  reg [63:0] dat_q;
  reg [7:0] crc_q;
  reg half_q;
  reg [2:0] cidx_q;
  reg [63:0] txd_q;
  reg [7:0] txcrc_q;
  reg [3:0] tcnt_q;
  reg [3:0] tidx_q;
  reg ee_q;
  wire [1:0] len = cw_q[`ICP_CW_LEN_HI:`ICP_CW_LEN_LO];
  wire crcen = cw_q[`ICP_CW_CRCEN];
  wire [3:0] nb = len_bytes(len);
  wire [2:0] didx = pidx_q[2:0] - 3'h3;
  // 22-bit location from section, page and address
  wire [21:0] base = {2'h0, cw_q[`ICP_CW_SEC_HI:`ICP_CW_SEC_LO], cw_q[`ICP_CW_PAGE_HI:`ICP_CW_PAGE_LO],
                      cw_q[`ICP_CW_ADDR_HI:`ICP_CW_ADDR_LO]};
  wire [21:0] cur_addr = half_q ? base + `ICP_WORD_STEP : base;
  wire [31:0] cur_word = half_q ? dat_q[63:32] : dat_q[31:0];
  wire wr_ok = ~cw_q[`ICP_CW_DIR] & (len != `ICP_LEN_RSVD) &
               (pidx_q == `ICP_CW_BYTES + nb + {3'h0, crcen}) & (~crcen | (crc_q == 8'h00));
  wire ee_hit = (cur_addr == `ICP_EE_CMD_ADDR) & (len != `ICP_LEN_16) &
                (cur_word == `ICP_EE_RELOAD_VAL);
  wire more = (len == `ICP_LEN_64) & ~half_q;
  wire q_ready;
  wire push = (pst_q == P_PUSH) & ~ee_hit;

  // running checksum over received bytes: a clean packet leaves zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pw_q <= 1'b0;
      pidx_q <= 4'h0;
      cw_q <= 24'h000000;
      dat_q <= 64'h0;
      crc_q <= `ICP_CRC_INIT;
      pst_q <= P_IDLE;
      half_q <= 1'b0;
      cidx_q <= 3'h0;
      txd_q <= 64'h0;
      txcrc_q <= 8'h00;
      tcnt_q <= 4'h0;
      tidx_q <= 4'h0;
      tx_valid_q <= 1'b0;
      ee_q <= 1'b0;
    end else begin
      ee_q <= 1'b0;
      if (addr_ev) begin
        pw_q <= ~is_rd;
        tidx_q <= 4'h0; // retried reads restart at the first byte
        if (!is_rd) begin
          pidx_q <= 4'h0;
          dat_q <= 64'h0;
          crc_q <= crc8_step(`ICP_CRC_INIT, sh_q);
        end
      end else if (rx_ev && pw_q) begin
        crc_q <= crc8_step(crc_q, sh_q);
        if (pidx_q != 4'hF) begin
          pidx_q <= pidx_q + 4'h1;
        end
        if (pidx_q < `ICP_CW_BYTES) begin
          cw_q <= {cw_q[15:0], sh_q};
        end else if (pidx_q < `ICP_CW_BYTES + nb) begin // checksum byte never lands in data
          dat_q[{didx, 3'h0} +: 8] <= sh_q;
        end
        // last control byte of a read: fetch now, reserved length ignored
        if (pidx_q == 4'h2 && cw_q[15] && cw_q[13:12] != `ICP_LEN_RSVD) begin
          pst_q <= P_RD;
          half_q <= 1'b0;
          tx_valid_q <= 1'b0;
          pw_q <= 1'b0;
        end
      end else if (stop_ev && pw_q) begin
        pw_q <= 1'b0;
        if (wr_ok) begin
          pst_q <= P_PUSH;
          half_q <= 1'b0;
        end
      end
      if (tx_done && tx_valid_q) begin
        tidx_q <= tidx_q + 4'h1;
        if (tidx_q + 4'h1 == tcnt_q) begin
          tx_valid_q <= 1'b0; // fully read: buffer released
        end
      end
      case (pst_q)
        P_IDLE: begin
        end
        P_RD: begin
          if (rd_ack) begin
            if (half_q) begin
              txd_q[63:32] <= rd_data;
            end else begin
              txd_q[31:0] <= rd_data;
            end
            if (more) begin
              half_q <= 1'b1;
            end else begin
              cidx_q <= 3'h0;
              crc_q <= crc8_step(crc_q, {tgt_q, 1'b1});
              pst_q <= P_CRC;
            end
          end
        end
        P_CRC: begin
          crc_q <= crc8_step(crc_q, txd_q[{cidx_q, 3'h0} +: 8]);
          cidx_q <= cidx_q + 3'h1;
          if ({1'b0, cidx_q} == nb - 4'h1) begin
            txcrc_q <= crc8_step(crc_q, txd_q[{cidx_q, 3'h0} +: 8]);
            tcnt_q <= nb + {3'h0, crcen};
            tidx_q <= 4'h0;
            tx_valid_q <= 1'b1;
            pst_q <= P_IDLE;
          end
        end
        P_PUSH: begin
          // reload only taken while the motor stands still
          if (ee_hit) begin
            ee_q <= motor_stationary;
          end
          if (ee_hit || q_ready) begin
            if (more) begin
              half_q <= 1'b1;
            end else begin
              pst_q <= P_IDLE;
            end
          end
        end
        default: pst_q <= P_IDLE;
      endcase
    end
  end
  assign eeprom_reload = ee_q;
  assign rd_req = (pst_q == P_RD);
  assign rd_addr = cur_addr;
  assign tx_byte = (tidx_q >= nb) ? txcrc_q : txd_q[{tidx_q[2:0], 3'h0} +: 8];

  // ----------------------------------------------------------------
  // write queue: stalls the push state when the register side lags
  // ----------------------------------------------------------------
  wire [54:0] q_out;
  icp_pair_buf #(.W(55), .AW(1)) u_wq (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(q_ready),
    .in_data({len != `ICP_LEN_16, cur_addr, cur_word}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(q_out)
  );
  assign wr_wide = q_out[54];
  assign wr_addr = q_out[53:32];
  assign wr_data = q_out[31:0];
endmodule
`default_nettype wire

/* File: verilog/icp_defs.vh */
/*
  Constants of the I2C packet engine: control word layout, length codes,
  checksum, target address reset value and special register values.
  Assumes inclusion by bare name from design files of the icp block.
*/
`ifndef ICP_DEFS_VH
`define ICP_DEFS_VH

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define ICP_CW_DIR 23
`define ICP_CW_CRCEN 22
`define ICP_CW_LEN_HI 21
`define ICP_CW_LEN_LO 20
`define ICP_CW_SEC_HI 19
`define ICP_CW_SEC_LO 16
`define ICP_CW_PAGE_HI 15
`define ICP_CW_PAGE_LO 12
`define ICP_CW_ADDR_HI 11
`define ICP_CW_ADDR_LO 0
`define ICP_CW_BYTES 4'h3

// ----------------------------------------------------------------
// length codes and values
// ----------------------------------------------------------------
`define ICP_LEN_16 2'h0
`define ICP_LEN_32 2'h1
`define ICP_LEN_64 2'h2
`define ICP_LEN_RSVD 2'h3
`define ICP_TARGET_ADDR_RST 7'h01
`define ICP_CRC_INIT 8'hFF
`define ICP_CRC_POLY 8'h07
`define ICP_WORD_STEP 22'h000002
`define ICP_EE_CMD_ADDR 22'h0000EA
`define ICP_EE_RELOAD_VAL 32'h40000000

`endif

/* File: verilog/icp_pair_buf.v */
/*
  Small valid/ready buffer of 2**AW entries, flip-flop storage.
  Assumes both sides run on ref_clk; full and empty are exact.
*/
`timescale 1ns/1ps
`default_nettype none
module icp_pair_buf #(
  parameter W = 55,
  parameter AW = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam DEPTH = 1 << AW;
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  integer i;

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];

  // storage is cleared on reset; only the count decides what is valid
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/icp_packet_engine_props.sv */
/*
  Concurrent checks on the ports of the packet engine.
  Assumes one clock domain, ref_clk, with rst asynchronous active high.
*/
`timescale 1ns/1ps
`default_nettype none
module icp_packet_engine_props (
  input wire ref_clk,
  input wire rst,
  input wire sda_oe,
  input wire [6:0] target_addr_cfg,
  input wire target_addr_load,
  input wire [6:0] target_addr,
  input wire wr_valid,
  input wire wr_ready,
  input wire [21:0] wr_addr,
  input wire [31:0] wr_data,
  input wire wr_wide,
  input wire rd_req,
  input wire [21:0] rd_addr,
  input wire rd_ack,
  input wire motor_stationary,
  input wire eeprom_reload
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst_val;
    $fell(rst) |-> target_addr == 7'h01 && !wr_valid && !rd_req && !sda_oe;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad state after reset");
  property p_addr_load;
    target_addr_load |=> target_addr == $past(target_addr_cfg);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("target address not loaded");
  property p_rd_hold;
    rd_req && !rd_ack |=> rd_req && $stable(rd_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped early");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable({wr_wide, wr_addr, wr_data});
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write entry lost");
  property p_wr_narrow;
    wr_valid && !wr_wide |-> wr_data[31:16] == 16'h0000;
  endproperty
  a_wr_narrow: assert property (p_wr_narrow) else $error("narrow write upper bits set");
  property p_reload_motor;
    eeprom_reload |-> $past(motor_stationary);
  endproperty
  a_reload_motor: assert property (p_reload_motor) else $error("reload while motor turns");
  property p_reload_pulse;
    eeprom_reload |=> !eeprom_reload;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse too long");
  property p_no_fwd;
    wr_valid |-> !(wr_addr == 22'h0000EA && wr_data == 32'h40000000);
  endproperty
  a_no_fwd: assert property (p_no_fwd) else $error("reload command forwarded");
  property p_addr_top;
    (wr_valid |-> wr_addr[21:20] == 2'h0) and (rd_req |-> rd_addr[21:20] == 2'h0);
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("address top bits set");
  // main scenarios reached
  c_pop: cover property (wr_valid && wr_ready && wr_wide);
  c_fetch: cover property (rd_req && rd_ack);
  c_reload: cover property (eeprom_reload);
endmodule
bind icp_packet_engine icp_packet_engine_props icp_packet_engine_props_i (
  .ref_clk(ref_clk), .rst(rst), .sda_oe(sda_oe), .target_addr_cfg(target_addr_cfg),
  .target_addr_load(target_addr_load), .target_addr(target_addr), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .wr_wide(wr_wide), .rd_req(rd_req),
  .rd_addr(rd_addr), .rd_ack(rd_ack), .motor_stationary(motor_stationary), .eeprom_reload(eeprom_reload)
);
`default_nettype wire

/* File: testbench/icp_ctl_model.sv */
/*
  Bus controller model: drives scl and an open-drain pull on sda.
  Assumes the bench resolves sda with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module icp_ctl_model #(
  parameter GAP = 4
) (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ------------------------------------------------------------
  // bit and byte phases, quarter bit is two clocks
  // ------------------------------------------------------------
  // scl stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (2) @(negedge ref_clk);
  endtask
  // sda moves only mid-low so no false start is seen
  task automatic bit_c(input logic b, output logic r);
    q();
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
  endtask
  task automatic start_c();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop_c();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic wr_b(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(b[i], r);
    bit_c(1'b1, r);
    ack = ~r;
    repeat (GAP) @(negedge ref_clk); // shortened byte pause
  endtask
  task automatic rd_b(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, b[i]);
    bit_c(~ack, r);
    repeat (GAP) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
/*
  Self-checking bench: packets through the controller model, a
  register side model for writes, fetches and reload pulses.
  Assumes design and checker files are compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst, wr_ready, rd_ack, motor_stationary, target_addr_load, last_ack;
  logic [6:0] target_addr_cfg;
  logic [31:0] rd_data;
  logic [7:0] crc;
  int checks, error_cnt, rd_lat, rd_cnt, rl_cnt;
  logic [54:0] wq[$];
  wire sda_out, sda_oe, wr_valid, wr_wide, rd_req, eeprom_reload, scl, m_low;
  wire [6:0] target_addr;
  wire [21:0] wr_addr, rd_addr;
  wire [31:0] wr_data;
  // open drain wire with pull-up
  wire sda_w = ~(m_low | (sda_oe & ~sda_out));
  icp_packet_engine icp_packet_engine_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .target_addr_cfg(target_addr_cfg), .target_addr_load(target_addr_load),
    .target_addr(target_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_wide(wr_wide), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data),
    .motor_stationary(motor_stationary), .eeprom_reload(eeprom_reload));
  icp_ctl_model icp_ctl_model_i (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_low(m_low));
  // ------------------------------------------------------------
  // register side model
  // ------------------------------------------------------------
  function automatic logic [31:0] f(input logic [21:0] a);
    return {10'h2A5, a};
  endfunction
  // record pops at the very edge that takes them; a falling-edge look races the bench's wr_ready change
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_wide, wr_addr, wr_data});
  end
  // answer fetches after rd_lat cycles, count reloads
  always @(negedge ref_clk) begin
    if (eeprom_reload === 1'b1) rl_cnt++;
    rd_ack <= 1'b0;
    if (rd_req === 1'b1 && !rd_ack) begin
      rd_cnt <= (rd_cnt == rd_lat) ? 0 : rd_cnt + 1;
      rd_ack <= (rd_cnt == rd_lat);
      rd_data <= (rd_cnt == rd_lat) ? f(rd_addr) : ~rd_data;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    crc = crc8(crc, b);
    icp_ctl_model_i.wr_b(b, last_ack);
  endtask
  // write packet; flip spoils the checksum byte
  task automatic wpkt(input logic [6:0] ta, input logic [23:0] cw, input logic [63:0] d, input int n,
    input logic [7:0] flip, input logic ack_exp);
    crc = 8'hFF;
    icp_ctl_model_i.start_c();
    send({ta, 1'b0});
    chk(last_ack, ack_exp);
    for (int i = 0; i < 3; i++) send(cw[23 - 8 * i -: 8]);
    for (int i = 0; i < n; i++) send(d[8 * i +: 8]);
    if (cw[22]) send(crc ^ flip);
    icp_ctl_model_i.stop_c();
    repeat (40) @(negedge ref_clk);
  endtask
  // read packet with address-only retries while refused
  task automatic rpkt(input logic [23:0] cw, input logic [63:0] exp, input int n);
    logic [7:0] b;
    logic [7:0] c2;
    logic [63:0] got;
    got = 64'h0;
    crc = 8'hFF;
    icp_ctl_model_i.start_c();
    send(8'h02);
    for (int i = 0; i < 3; i++) send(cw[23 - 8 * i -: 8]);
    c2 = crc;
    last_ack = 1'b0;
    for (int k = 0; k < 20 && last_ack !== 1'b1; k++) begin
      if (k > 0) icp_ctl_model_i.stop_c();
      if (k > 0) repeat (100) @(negedge ref_clk);
      crc = c2;
      icp_ctl_model_i.start_c();
      send(8'h03);
    end
    chk(last_ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      icp_ctl_model_i.rd_b(b, i < n - 1 || cw[22]);
      got[8 * i +: 8] = b;
      crc = crc8(crc, b);
    end
    if (cw[22]) icp_ctl_model_i.rd_b(b, 1'b0);
    if (cw[22]) chk(b, crc);
    icp_ctl_model_i.stop_c();
    chk(got, exp);
    repeat (40) @(negedge ref_clk);
  endtask
  task automatic take(input logic [54:0] e);
    for (int k = 0; k < 400 && wq.size() == 0; k++) @(negedge ref_clk);
    chk(wq.size() != 0 ? wq.pop_front() : 64'hX, e);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // run needs about 9k cycles
  initial begin
    repeat (80000) @(negedge ref_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    {rst, wr_ready, motor_stationary, target_addr_load, rd_ack} = 5'h10;
    target_addr_cfg = 7'h00;
    rd_data = 32'h0;
    rd_lat = 0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    wr_ready = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(target_addr, 7'h01);
    wpkt(7'h01, 24'h500080, 64'h1234ABCD, 4, 8'h00, 1'b1);
    take({1'b1, 22'h000080, 32'h1234ABCD});
    $display("test 1 done");
    wr_ready = 1'b0;
    wpkt(7'h01, 24'h235010, 64'h89ABCDEF01234567, 8, 8'h00, 1'b1);
    chk(wr_valid, 1'b1);
    wr_ready = 1'b1;
    take({1'b1, 22'h035010, 32'h01234567});
    take({1'b1, 22'h035012, 32'h89ABCDEF});
    $display("test 2 done");
    wpkt(7'h01, 24'h400084, 64'h5555, 2, 8'h01, 1'b1);
    wpkt(7'h01, 24'h300086, 64'h5555, 2, 8'h00, 1'b1);
    wpkt(7'h01, 24'h100088, 64'h5555, 2, 8'h00, 1'b1);
    chk(64'(wq.size()), 64'h0);
    $display("test 3 done");
    rd_lat = 200; // long fetch: the first read address is refused and retried
    rpkt(24'hD00080, {32'h0, f(22'h000080)}, 4);
    rd_lat = 0;
    rpkt(24'hA00090, {f(22'h000092), f(22'h000090)}, 8);
    $display("test 4 done");
    wpkt(7'h01, 24'h1000EA, 64'h40000000, 4, 8'h00, 1'b1);
    chk(64'(rl_cnt), 64'h0);
    motor_stationary = 1'b1;
    wpkt(7'h01, 24'h1000EA, 64'h40000000, 4, 8'h00, 1'b1);
    chk(64'(rl_cnt), 64'h1);
    chk(64'(wq.size()), 64'h0);
    repeat (200) @(negedge ref_clk); // shortened reload wait
    rpkt(24'h8000A0, 64'h00A0, 2);
    $display("test 5 done");
    target_addr_cfg = 7'h22;
    target_addr_load = 1'b1;
    @(negedge ref_clk);
    target_addr_load = 1'b0;
    chk(target_addr, 7'h22);
    wpkt(7'h01, 24'h0000A2, 64'hBEEF, 2, 8'h00, 1'b0);
    wpkt(7'h22, 24'h4000A2, 64'hBEEF, 2, 8'h00, 1'b1);
    take({1'b0, 22'h0000A2, 32'h0000BEEF});
    $display("test 6 done");
    test_done();
  end
endmodule
`default_nettype wire
